// ---- hdl/sensor_serial_port.sv ----
module sensor_serial_port (
	input  wire logic                            clk,          // 20 MHz system clock
	input  wire logic                            resetn,       // sync reset, active low
	input  wire logic                            sclk,         // serial clock from master
	input  wire logic                            chip_select_n, // port select, active low
	input  wire logic                            sdio_in,      // data line level
	output wire logic                            sdio_out,     // data line drive value
	output wire logic                            sdio_oe,      // high while driving data line
	output wire logic                            motion_n,     // motion indicator, active low
	output wire logic                            port_clock_on, // port write clock enabled
	input  wire sensor_port_pkg::motion_sample_t motion_in     // displacement from core
);
	import sensor_port_pkg::*;

	state_t     s;
	state_t     n;
	logic       rise;
	logic       fall;
	logic       wr_go;
	logic       clear;
	logic [7:0] byte_in;

	function automatic logic [7:0] reg_read(input logic [6:0] a, input state_t st);
		logic [7:0] d;
		d = 8'h00;
		case (a)
			ADDR_MOTION:        d[MOTION_FLAG_BIT] = st.motion_flag;
			ADDR_DELTA_X_LOW:   d = st.dx[7:0];
			ADDR_DELTA_Y_LOW:   d = st.dy[7:0];
			ADDR_UPPER_NIBBLES: d = {st.dx[11:8], st.dy[11:8]};
			default:            d = 8'h00;
		endcase
		return d;
	endfunction : reg_read

	always_comb begin
		n = s;
		wr_go = 1'b0;
		// only the master's clock is sampled, never produced here
		n.sclk_s1 = sclk;
		n.sclk_s2 = s.sclk_s1;
		n.sclk_prev = s.sclk_s2;
		n.cs_s1 = chip_select_n;
		n.cs_s2 = s.cs_s1;
		n.sdio_s1 = sdio_in;
		n.sdio_s2 = s.sdio_s1;
		rise = s.sclk_s2 & ~s.sclk_prev;
		fall = ~s.sclk_s2 & s.sclk_prev;
		byte_in = {s.shift[6:0], s.sdio_s2};
		if (s.cs_s2) begin
			n.phase = PH_IDLE;
			n.bit_cnt = 4'h0;
			n.sdio_oe = 1'b0;
		end else begin
			unique case (s.phase)
				PH_IDLE: begin
					n.phase = PH_ADDR;
					n.bit_cnt = 4'h0;
				end
				PH_ADDR, PH_WDATA: begin
					if (rise) begin
						n.shift = byte_in;
						n.bit_cnt = s.bit_cnt + 4'h1;
						if (s.bit_cnt == LAST_BIT) begin
							n.bit_cnt = 4'h0;
							if (s.phase == PH_WDATA) begin
								wr_go = 1'b1;
								n.phase = PH_ADDR;
							end else if (byte_in[7]) begin
								n.addr = byte_in[6:0];
								n.phase = PH_WDATA;
							end else begin
								n.tx = reg_read(byte_in[6:0], s);
								n.phase = PH_RDATA;
							end
						end
					end
				end
				PH_RDATA: begin
					if (fall) begin
						if (s.bit_cnt != BITS_PER_BYTE) begin
							n.sdio_out = s.tx[7];
							n.tx = {s.tx[6:0], 1'b0};
							n.sdio_oe = 1'b1;
							n.bit_cnt = s.bit_cnt + 4'h1;
						end else begin
							// this fall already opens the next command
							n.sdio_oe = 1'b0;
							n.phase = PH_ADDR;
							n.bit_cnt = 4'h0;
						end
					end
				end
			endcase
		end
		// the request register is always writable, else the port could never wake
		if (wr_go && s.addr == ADDR_PORT_CLOCK_REQUEST) begin
			if (byte_in == PORT_CLOCK_ON_CODE) begin
				n.port_clk_on = 1'b1;
			end else if (byte_in == PORT_CLOCK_OFF_CODE) begin
				n.port_clk_on = 1'b0;
			end
		end
		clear = wr_go && s.port_clk_on && s.addr == ADDR_MOTION;
		if (clear) begin
			n.motion_flag = 1'b0;
			n.dx = '0;
			n.dy = '0;
		end
		// new motion wins over a clear in the same cycle
		if (motion_in.valid) begin
			n.motion_flag = 1'b1;
			n.dx = (clear ? '0 : s.dx) + motion_in.dx;
			n.dy = (clear ? '0 : s.dy) + motion_in.dy;
		end
		n.motion_n = ~n.motion_flag;
	end

	always_ff @(posedge clk) begin
		s <= resetn ? n : STATE_RESET;
	end

	assign sdio_out = s.sdio_out;
	assign sdio_oe = s.sdio_oe;
	assign motion_n = s.motion_n;
	assign port_clock_on = s.port_clk_on;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	property p_motion_pin;
		motion_in.valid |=> !motion_n && s.motion_flag;
	endproperty
	a_motion_pin: assert property (p_motion_pin) else $error("motion pin not low after event");

	property p_motion_hold;
		s.motion_flag && !clear |=> !motion_n;
	endproperty
	a_motion_hold: assert property (p_motion_hold) else $error("motion pin released early");

	property p_deselect_quiet;
		s.cs_s2 |=> !sdio_oe && s.phase == PH_IDLE;
	endproperty
	a_deselect_quiet: assert property (p_deselect_quiet) else $error("active while deselected");

	property p_drive_only_read;
		sdio_oe |-> s.phase == PH_RDATA;
	endproperty
	a_drive_only_read: assert property (p_drive_only_read) else $error("drive outside read");

	property p_sample_rise;
		s.phase == PH_ADDR && rise && s.bit_cnt != LAST_BIT && !s.cs_s2
			|=> s.shift[0] == $past(s.sdio_s2) && s.bit_cnt == $past(s.bit_cnt) + 4'h1;
	endproperty
	a_sample_rise: assert property (p_sample_rise) else $error("rising edge bit not taken");

	property p_read_turn;
		s.phase == PH_ADDR && rise && s.bit_cnt == LAST_BIT && !byte_in[7] && !s.cs_s2
			|=> s.phase == PH_RDATA && s.bit_cnt == 4'h0 && !sdio_oe;
	endproperty
	a_read_turn: assert property (p_read_turn) else $error("read byte not entered");

	property p_fall_drive;
		s.phase == PH_RDATA && fall && s.bit_cnt != BITS_PER_BYTE && !s.cs_s2
			|=> sdio_oe && sdio_out == $past(s.tx[7]);
	endproperty
	a_fall_drive: assert property (p_fall_drive) else $error("read bit not driven on fall");

	property p_hold_last;
		sdio_oe && !fall && !s.cs_s2 |=> sdio_oe && $stable(sdio_out);
	endproperty
	a_hold_last: assert property (p_hold_last) else $error("read bit changed without fall");

	property p_clock_on;
		wr_go && s.addr == ADDR_PORT_CLOCK_REQUEST && byte_in == PORT_CLOCK_ON_CODE
			|=> port_clock_on;
	endproperty
	a_clock_on: assert property (p_clock_on) else $error("port clock not enabled");

	property p_clock_off;
		wr_go && s.addr == ADDR_PORT_CLOCK_REQUEST && byte_in == PORT_CLOCK_OFF_CODE
			|=> !port_clock_on;
	endproperty
	a_clock_off: assert property (p_clock_off) else $error("port clock not disabled");

	property p_unmapped_write;
		wr_go && !motion_in.valid && s.addr != ADDR_MOTION
			&& s.addr != ADDR_PORT_CLOCK_REQUEST
			|=> $stable(s.dx) && $stable(s.dy) && $stable(s.motion_flag)
			&& $stable(s.port_clk_on);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write acted");

	property p_gated_clear;
		wr_go && !s.port_clk_on && !motion_in.valid && s.addr == ADDR_MOTION
			|=> $stable(s.motion_flag) && $stable(s.dx) && $stable(s.dy);
	endproperty
	a_gated_clear: assert property (p_gated_clear) else $error("gated write acted");

	property p_read_end;
		s.phase == PH_RDATA && fall && s.bit_cnt == BITS_PER_BYTE && !s.cs_s2
			|=> !sdio_oe && s.phase == PH_ADDR && s.bit_cnt == 4'h0;
	endproperty
	a_read_end: assert property (p_read_end) else $error("read drive not ended");

	c_write_done: cover property (wr_go && s.port_clk_on);
	c_read_done: cover property (s.phase == PH_RDATA && fall && s.bit_cnt == BITS_PER_BYTE);
	c_motion_clear: cover property (!motion_n ##[1:1000] clear);
	c_clock_on: cover property ($rose(port_clock_on));
endmodule : sensor_serial_port

// ---- pkg/sensor_port_pkg.sv ----
package sensor_port_pkg;
	localparam int         DELTA_W                 = 12;
	localparam logic [6:0] ADDR_MOTION             = 7'h02;
	localparam logic [6:0] ADDR_DELTA_X_LOW        = 7'h03;
	localparam logic [6:0] ADDR_DELTA_Y_LOW        = 7'h04;
	localparam logic [6:0] ADDR_UPPER_NIBBLES      = 7'h05;
	localparam logic [6:0] ADDR_PORT_CLOCK_REQUEST = 7'h41;
	localparam logic [7:0] PORT_CLOCK_ON_CODE      = 8'hBA;
	localparam logic [7:0] PORT_CLOCK_OFF_CODE     = 8'hB5;
	localparam int         MOTION_FLAG_BIT         = 7;
	localparam logic [3:0] LAST_BIT                = 4'h7;
	localparam logic [3:0] BITS_PER_BYTE           = 4'h8;

	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_ADDR  = 2'b01,
		PH_WDATA = 2'b10,
		PH_RDATA = 2'b11
	} phase_t;

	typedef struct packed {
		logic               valid;
		logic [DELTA_W-1:0] dx;
		logic [DELTA_W-1:0] dy;
	} motion_sample_t;

	typedef struct packed {
		logic               sclk_s1;
		logic               sclk_s2;
		logic               sclk_prev;
		logic               cs_s1;
		logic               cs_s2;
		logic               sdio_s1;
		logic               sdio_s2;
		phase_t             phase;
		logic [3:0]         bit_cnt;
		logic [7:0]         shift;
		logic [6:0]         addr;
		logic [7:0]         tx;
		logic               sdio_out;
		logic               sdio_oe;
		logic               port_clk_on;
		logic               motion_flag;
		logic               motion_n;
		logic [DELTA_W-1:0] dx;
		logic [DELTA_W-1:0] dy;
	} state_t;

	// sclk idles high; a low reset value would fake a rise just after reset
	localparam state_t STATE_RESET = '{
		sclk_s1:   1'b1,
		sclk_s2:   1'b1,
		sclk_prev: 1'b1,
		cs_s1:    1'b1,
		cs_s2:    1'b1,
		motion_n: 1'b1,
		phase:    PH_IDLE,
		default:  '0
	};
endpackage : sensor_port_pkg

// ---- tb/host_model.sv ----
module host_model (
	input  wire logic       clk,           // bench clock
	output logic            sclk,          // serial clock to device
	output logic            chip_select_n, // select, active low
	output wire logic       sdio_line,     // resolved data wire
	input  wire logic       sdio_out,      // device drive value
	input  wire logic       sdio_oe,       // device drive enable
	output logic            rd_valid,      // one-cycle pulse, read byte ready
	output logic [7:0]      rd_data        // byte read back
);
	timeunit 1ns;
	timeprecision 1ns;
	logic host_en;
	logic host_d;

	// released wire shows the inverse of the last bit, never a stale copy
	assign sdio_line = sdio_oe ? sdio_out : (host_en ? host_d : ~host_d);

	initial begin
		sclk = 1'b1;
		chip_select_n = 1'b1;
		host_en = 1'b0;
		host_d = 1'b0;
		rd_valid = 1'b0;
		rd_data = 8'h00;
	end

	// fewer than 16 bits aborts the command by raising select
	task automatic cmd(input logic [7:0] a, input logic [7:0] d, input int nbits);
		logic [15:0] w;
		w = {a, d};
		chip_select_n <= 1'b0;
		repeat (5) @(posedge clk);
		for (int i = 0; i < nbits; i++) begin
			sclk <= 1'b0;
			host_en <= !(!a[7] && i >= 8);
			host_d <= w[15-i];
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			repeat (2) @(posedge clk);
			if (!a[7] && i >= 8) rd_data <= {rd_data[6:0], sdio_line};
			repeat (2) @(posedge clk);
		end
		repeat (6) @(posedge clk);
		chip_select_n <= 1'b1;
		host_en <= 1'b0;
		rd_valid <= !a[7] && nbits == 16;
		@(posedge clk);
		rd_valid <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : cmd
endmodule : host_model

// ---- tb/testbench.sv ----
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import sensor_port_pkg::*;
	logic clk;
	logic resetn;
	motion_sample_t motion_in;
	wire logic sclk, chip_select_n, sdio_line, sdio_out, sdio_oe;
	wire logic motion_n, port_clock_on, rd_valid;
	wire logic [7:0] rd_data;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [7:0] expq[$];
	logic [11:0] sx = '0;
	logic [11:0] sy = '0;

	sensor_serial_port sensor_serial_port_inst (.clk(clk), .resetn(resetn), .sclk(sclk),
		.chip_select_n(chip_select_n), .sdio_in(sdio_line), .sdio_out(sdio_out),
		.sdio_oe(sdio_oe), .motion_n(motion_n), .port_clock_on(port_clock_on),
		.motion_in(motion_in));
	host_model host_model_inst (.clk(clk), .sclk(sclk), .chip_select_n(chip_select_n),
		.sdio_line(sdio_line), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.rd_valid(rd_valid), .rd_data(rd_data));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		expq.push_back(e);
		host_model_inst.cmd({1'b0, a}, 8'($urandom), 16);
	endtask : rd

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host_model_inst.cmd({1'b1, a}, d, 16);
	endtask : wr

	task automatic mot(input logic [11:0] x, input logic [11:0] y);
		sx += x;
		sy += y;
		motion_in <= '{valid: 1'b1, dx: x, dy: y};
		@(posedge clk);
		motion_in.valid <= 1'b0;
		@(posedge clk);
	endtask : mot

	always @(posedge clk) begin
		cycles++;
		if (rd_valid === 1'b1) chk("read byte", expq.pop_front(), rd_data);
		if (cycles == 8000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	initial begin
		resetn = 1'b0;
		motion_in = '0;
		void'($urandom(32'h69237684));
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		chk("motion_n", 8'h01, {7'h00, motion_n});
		chk("port_clock_on", 8'h00, {7'h00, port_clock_on});
		rd(ADDR_MOTION, 8'h00);
		rd(7'h7F, 8'h00);
		rd(ADDR_PORT_CLOCK_REQUEST, 8'h00);
		wr(ADDR_PORT_CLOCK_REQUEST, 8'h99);
		chk("port_clock_on", 8'h00, {7'h00, port_clock_on});
		wr(ADDR_PORT_CLOCK_REQUEST, PORT_CLOCK_ON_CODE);
		chk("port_clock_on", 8'h01, {7'h00, port_clock_on});
		$display("test port clock done");
		mot(12'($urandom), 12'($urandom));
		mot(12'($urandom), 12'($urandom));
		chk("motion_n", 8'h00, {7'h00, motion_n});
		rd(ADDR_MOTION, 8'h80);
		rd(ADDR_DELTA_X_LOW, sx[7:0]);
		rd(ADDR_DELTA_Y_LOW, sy[7:0]);
		rd(ADDR_UPPER_NIBBLES, {sx[11:8], sy[11:8]});
		host_model_inst.cmd({1'b0, ADDR_DELTA_Y_LOW}, 8'h00, 5);
		rd(ADDR_DELTA_X_LOW, sx[7:0]);
		$display("test motion read done");
		wr(ADDR_MOTION, 8'h00);
		chk("motion_n", 8'h01, {7'h00, motion_n});
		sx = '0;
		sy = '0;
		rd(ADDR_DELTA_X_LOW, 8'h00);
		wr(ADDR_PORT_CLOCK_REQUEST, PORT_CLOCK_OFF_CODE);
		chk("port_clock_on", 8'h00, {7'h00, port_clock_on});
		mot(12'h001, 12'h000);
		wr(ADDR_MOTION, 8'h00);
		chk("motion_n", 8'h00, {7'h00, motion_n});
		rd(ADDR_DELTA_X_LOW, sx[7:0]);
		$display("test clear and gating done");
		repeat (4) @(posedge clk);
		tally_and_finish();
	end
endmodule : testbench
